// >>> include/perf_monitor_pkg.sv
`default_nettype none

package perf_monitor_pkg;

  // Register offsets on the 8-bit host address bus.
  localparam logic [7:0] LINE_VIOL_CNT_HI_ADDR = 8'h50;
  localparam logic [7:0] LINE_VIOL_CNT_LO_ADDR = 8'h51;
  localparam logic [7:0] PPB_CNT_HI_ADDR = 8'h58;
  localparam logic [7:0] PPB_CNT_LO_ADDR = 8'h59;
  localparam logic [7:0] HOLD_ADDR = 8'h6c;
  localparam logic [7:0] SEC_STATUS_ADDR = 8'h6d;
  localparam logic [7:0] SEC_LINE_VIOL_HI_ADDR = 8'h6e;
  localparam logic [7:0] SEC_LINE_VIOL_LO_ADDR = 8'h6f;
  localparam logic [7:0] SEC_PAR_HI_ADDR = 8'h70;
  localparam logic [7:0] SEC_PAR_LO_ADDR = 8'h71;

  // Field positions inside the one-second status register.
  localparam int ERRORED_SEC_BIT = 1;
  localparam int SEVERE_SEC_BIT = 0;

  // Reset values.
  localparam logic [15:0] COUNT_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;

  // Framing formats selected by the receive framer configuration.
  typedef enum logic [1:0] {
    FMT_DS3_CBIT = 2'h0,
    FMT_DS3_M13 = 2'h1,
    FMT_E3_G751 = 2'h2,
    FMT_E3_G832 = 2'h3
  } framing_fmt_t;

  // One-second interval, in nanoseconds, and its cycle count at 100 MHz.
  localparam longint SECOND_NS = 1000000000;
  localparam longint CLK_PERIOD_NS = 10;
  localparam int SECOND_CYCLES = int'(SECOND_NS / CLK_PERIOD_NS);

  // Severe threshold is one error in this many observed bits.
  localparam int SEVERE_RATIO = 1000;

endpackage

`default_nettype wire

// >>> logic/perf_monitor_counters.sv
`timescale 1ns/1ps
`default_nettype none

module perf_monitor_counters #(
  parameter int SECOND_CYCLES = perf_monitor_pkg::SECOND_CYCLES
) (
  // Clock and reset.
  input wire logic i_clk_sys,
  input wire logic i_rst,
  // Host register port: one-cycle read strobe with address.
  input wire logic i_rd_stb,
  input wire logic [7:0] i_addr,
  // Host read data, three-state bus split into data and enable.
  output logic [7:0] o_data,
  output logic o_data_oe,
  // Channel configuration.
  input wire logic [1:0] i_framing_fmt,
  // Error events from the receive framer, one-cycle pulses.
  input wire logic i_line_code_violation,
  input wire logic i_path_parity_bit_err,
  input wire logic i_frame_parity_err,
  // Bit-time strobe, one pulse per received bit, for the error rate.
  input wire logic i_bit_stb
);

  // Width of the one-second divider.
  localparam int SW = $clog2(SECOND_CYCLES + 1);

  // Saturating increment so a long interval never wraps to a small count.
  function automatic logic [15:0] bump(input logic [15:0] v, input logic ev);
    bump = (ev && v != 16'hffff) ? v + 16'h0001 : v;
  endfunction

  // Read-clear path parity error count since the last read.
  logic [15:0] ppb_cnt_q, ppb_cnt_d;
  // Read-clear line violation count since the last read.
  logic [15:0] viol_cnt_q, viol_cnt_d;
  // Holding byte: the unread half of the last counter read.
  logic [7:0] hold_q, hold_d;
  // Running line violation count of the current interval.
  logic [15:0] run_viol_q, run_viol_d;
  // Running frame parity count of the current interval.
  logic [15:0] run_par_q, run_par_d;
  // Running count of errored cycles, the numerator of the rate.
  logic [15:0] run_err_q, run_err_d;
  // Running count of received bits, the denominator of the rate.
  // It is wide so a full second of line bits never overflows it.
  logic [31:0] run_bits_q, run_bits_d;
  // Published line violation count of the last interval.
  logic [15:0] sec_viol_q, sec_viol_d;
  // Published frame parity count of the last interval.
  logic [15:0] sec_par_q, sec_par_d;
  // Errored second flag.
  logic es_q, es_d;
  // Severely errored second flag.
  logic ses_q, ses_d;
  // One-second divider.
  logic [SW-1:0] tick_q, tick_d;
  // Registered read data and bus drive enable.
  logic [7:0] data_q, data_d;
  logic oe_q, oe_d;
  // Per-cycle helpers.
  // High in the last cycle of each interval.
  logic second_end;
  // Path parity event after the framing gate.
  logic ppb_ev;
  // Any counted error in this cycle.
  logic any_err;

  // Derived event terms.
  always_comb begin
    // Only C-bit parity framing carries path parity bits.
    ppb_ev = i_path_parity_bit_err &&
      (i_framing_fmt == perf_monitor_pkg::FMT_DS3_CBIT);
    // The framer reports the frame parity type of the active format.
    any_err = i_line_code_violation | ppb_ev | i_frame_parity_err;
    // The interval closes on its last cycle so that cycle's events still count.
    second_end = (tick_q == SW'(SECOND_CYCLES - 1));
  end

  // Next-state logic for counters, holding byte and read data.
  always_comb begin
    ppb_cnt_d = bump(ppb_cnt_q, ppb_ev);
    viol_cnt_d = bump(viol_cnt_q, i_line_code_violation);
    hold_d = hold_q;
    data_d = data_q;
    oe_d = 1'b0;
    tick_d = second_end ? '0 : tick_q + SW'(1);
    // Running event counts saturate, as a full second can exceed their 16-bit range; the bit count wraps.
    run_viol_d = bump(run_viol_q, i_line_code_violation);
    run_par_d = bump(run_par_q, i_frame_parity_err);
    run_err_d = bump(run_err_q, any_err);
    run_bits_d = run_bits_q + (i_bit_stb ? 32'h1 : 32'h0);
    sec_viol_d = sec_viol_q;
    sec_par_d = sec_par_q;
    es_d = es_q;
    ses_d = ses_q;
    if (second_end) begin
      // Publish the interval and start the next one from zero.
      sec_viol_d = run_viol_d;
      sec_par_d = run_par_d;
      es_d = (run_err_d != 16'h0000);
      // Rate above 1/1000 means errors times 1000 exceed bits seen.
      ses_d = (32'(run_err_d) * 32'(perf_monitor_pkg::SEVERE_RATIO)) >
        run_bits_d;
      run_viol_d = perf_monitor_pkg::COUNT_RESET;
      run_par_d = perf_monitor_pkg::COUNT_RESET;
      run_err_d = perf_monitor_pkg::COUNT_RESET;
      run_bits_d = 32'h0;
    end
    if (i_rd_stb) begin
      oe_d = 1'b1;
      case (i_addr)
        // A first byte read clears the counter; an event in the same
        // cycle starts the new count so it is not lost.
        perf_monitor_pkg::PPB_CNT_HI_ADDR: begin
          data_d = ppb_cnt_q[15:8];
          hold_d = ppb_cnt_q[7:0];
          ppb_cnt_d = {15'h0000, ppb_ev};
        end
        perf_monitor_pkg::PPB_CNT_LO_ADDR: begin
          data_d = ppb_cnt_q[7:0];
          hold_d = ppb_cnt_q[15:8];
          ppb_cnt_d = {15'h0000, ppb_ev};
        end
        // The line violation counter pairs with the same holding byte.
        perf_monitor_pkg::LINE_VIOL_CNT_HI_ADDR: begin
          data_d = viol_cnt_q[15:8];
          hold_d = viol_cnt_q[7:0];
          viol_cnt_d = {15'h0000, i_line_code_violation};
        end
        perf_monitor_pkg::LINE_VIOL_CNT_LO_ADDR: begin
          data_d = viol_cnt_q[7:0];
          hold_d = viol_cnt_q[15:8];
          viol_cnt_d = {15'h0000, i_line_code_violation};
        end
        // Second access of the pair returns the stored byte, then clears.
        perf_monitor_pkg::HOLD_ADDR: begin
          data_d = hold_q;
          hold_d = perf_monitor_pkg::BYTE_RESET;
        end
        // Status and accumulators are read-only and have no read side effect.
        perf_monitor_pkg::SEC_STATUS_ADDR: begin
          data_d = 8'h00;
          data_d[perf_monitor_pkg::ERRORED_SEC_BIT] = es_q;
          data_d[perf_monitor_pkg::SEVERE_SEC_BIT] = ses_q;
        end
        perf_monitor_pkg::SEC_LINE_VIOL_HI_ADDR: begin
          data_d = sec_viol_q[15:8];
        end
        perf_monitor_pkg::SEC_LINE_VIOL_LO_ADDR: begin
          data_d = sec_viol_q[7:0];
        end
        perf_monitor_pkg::SEC_PAR_HI_ADDR: begin
          data_d = sec_par_q[15:8];
        end
        perf_monitor_pkg::SEC_PAR_LO_ADDR: begin
          data_d = sec_par_q[7:0];
        end
        // Unmapped addresses read as zero.
        default: begin
          data_d = 8'h00;
        end
      endcase
    end
  end

  // Register stage; every register clears to zero.
  always_ff @(posedge i_clk_sys) begin
    if (i_rst) begin
      ppb_cnt_q <= perf_monitor_pkg::COUNT_RESET;
      viol_cnt_q <= perf_monitor_pkg::COUNT_RESET;
      hold_q <= perf_monitor_pkg::BYTE_RESET;
      run_viol_q <= perf_monitor_pkg::COUNT_RESET;
      run_par_q <= perf_monitor_pkg::COUNT_RESET;
      run_err_q <= perf_monitor_pkg::COUNT_RESET;
      run_bits_q <= 32'h0;
      sec_viol_q <= perf_monitor_pkg::COUNT_RESET;
      sec_par_q <= perf_monitor_pkg::COUNT_RESET;
      es_q <= 1'b0;
      ses_q <= 1'b0;
      tick_q <= '0;
      data_q <= perf_monitor_pkg::BYTE_RESET;
      oe_q <= 1'b0;
    end else begin
      ppb_cnt_q <= ppb_cnt_d;
      viol_cnt_q <= viol_cnt_d;
      hold_q <= hold_d;
      run_viol_q <= run_viol_d;
      run_par_q <= run_par_d;
      run_err_q <= run_err_d;
      run_bits_q <= run_bits_d;
      sec_viol_q <= sec_viol_d;
      sec_par_q <= sec_par_d;
      es_q <= es_d;
      ses_q <= ses_d;
      tick_q <= tick_d;
      data_q <= data_d;
      oe_q <= oe_d;
    end
  end

  // Read data comes from flip-flops; the bus is driven for one cycle.
  assign o_data = data_q;
  assign o_data_oe = oe_q;

endmodule

`default_nettype wire

// >>> bench/perf_monitor_counters_chk.sv
`timescale 1ns/1ps
`default_nettype none
module perf_monitor_counters_chk (
  input wire logic i_clk_sys,
  input wire logic i_rst,
  input wire logic i_rd_stb,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] o_data,
  input wire logic o_data_oe,
  input wire logic i_path_parity_bit_err
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_rst);
  property p_oe; i_rd_stb |=> o_data_oe; endproperty
  a_oe: assert property (p_oe) else $error("no drive");
  property p_idle; !i_rd_stb |=> !o_data_oe && $stable(o_data); endproperty
  a_idle: assert property (p_idle) else $error("idle bus moved");
  property p_rst; disable iff (1'b0) i_rst |=> o_data == 8'h00 && !o_data_oe; endproperty
  a_rst: assert property (p_rst) else $error("reset value");
  property p_stat; i_rd_stb && i_addr == 8'h6d |=> o_data[7:2] == 6'h00; endproperty
  a_stat: assert property (p_stat) else $error("status spare bits");
  property p_unmap; i_rd_stb && i_addr == 8'h60 |=> o_data == 8'h00; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  // A second read right behind the first must see the cleared count.
  property p_rc; (i_rd_stb && i_addr == 8'h58 && !i_path_parity_bit_err) [*2] |=> o_data == 8'h00;
  endproperty
  a_rc: assert property (p_rc) else $error("count not cleared");
  property p_lo; (i_rd_stb && i_addr == 8'h59 && !i_path_parity_bit_err) [*2] |=> o_data == 8'h00;
  endproperty
  a_lo: assert property (p_lo) else $error("low count not cleared");
  property p_hold; (i_rd_stb && i_addr == 8'h6c) [*2] |=> o_data == 8'h00; endproperty
  a_hold: assert property (p_hold) else $error("holding not cleared");
  c_rc: cover property ((i_rd_stb && i_addr == 8'h58) [*2]);
  c_sec: cover property (i_rd_stb && i_addr == 8'h6d ##1 o_data[1:0] == 2'h3);
  c_hold: cover property (i_rd_stb && i_addr == 8'h6c ##1 o_data != 8'h00);
endmodule
bind perf_monitor_counters perf_monitor_counters_chk u_chk (.i_clk_sys(i_clk_sys),
  .i_rst(i_rst), .i_rd_stb(i_rd_stb), .i_addr(i_addr), .o_data(o_data),
  .o_data_oe(o_data_oe), .i_path_parity_bit_err(i_path_parity_bit_err));
`default_nettype wire

// >>> bench/perf_monitor_host.sv
`timescale 1ns/1ps
`default_nettype none
module perf_monitor_host (
  input wire logic i_clk_sys,
  input wire logic [7:0] i_data,
  output logic o_rd_stb,
  output logic [7:0] o_addr
);
  initial begin
    o_rd_stb = 1'b0;
    o_addr = 8'hff;
  end
  // Issues n back-to-back reads of one address; the idle address is inverted.
  // A full count takes a counter read, then a holding read.
  task automatic read(input logic [7:0] a, input int n, output logic [7:0] d);
    @(negedge i_clk_sys);
    o_rd_stb = 1'b1;
    o_addr = a;
    repeat (n) begin
      @(negedge i_clk_sys);
      d = i_data;
    end
    o_rd_stb = 1'b0;
    o_addr = ~a;
  endtask
endmodule
`default_nettype wire

// >>> bench/perf_monitor_counters_tb.sv
`timescale 1ns/1ps
`default_nettype none
module perf_monitor_counters_tb;
  logic i_clk_sys = 1'b0;
  logic i_rst = 1'b1;
  logic stb, oe, viol = 0, ppb = 0, fpe = 0, bit_stb = 0;
  logic [1:0] fmt = 2'h0;
  logic [7:0] addr, data, d;
  int fails = 0, comparisons = 0;
  always #5 i_clk_sys = ~i_clk_sys;
  perf_monitor_counters #(.SECOND_CYCLES(1100)) u_dut (.i_clk_sys(i_clk_sys), .i_rst(i_rst),
    .i_rd_stb(stb), .i_addr(addr), .o_data(data), .o_data_oe(oe), .i_framing_fmt(fmt),
    .i_line_code_violation(viol), .i_path_parity_bit_err(ppb), .i_frame_parity_err(fpe),
    .i_bit_stb(bit_stb));
  perf_monitor_host u_host (.i_clk_sys(i_clk_sys), .i_data(data), .o_rd_stb(stb), .o_addr(addr));
  // Compares a value seen against the value the rules expect.
  task automatic check(input logic [7:0] a, input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      fails++;
      $display("Error reg %h expected %h seen %h", a, exp, seen);
    end
  endtask
  task automatic rd(input logic [7:0] a, input int n, input logic [7:0] e);
    u_host.read(a, n, d);
    check(a, d, e);
  endtask
  // Holds the path parity error line high for n cycles.
  task automatic pulse(input int n);
    ppb = 1'b1;
    repeat (n) @(negedge i_clk_sys);
    ppb = 1'b0;
  endtask
  task automatic t_ppb;
    logic [7:0] m[11] = '{8'h50, 8'h51, 8'h58, 8'h59, 8'h6c, 8'h6d, 8'h6e, 8'h6f,
      8'h70, 8'h71, 8'h60};
    foreach (m[i]) rd(m[i], 1, 8'h00);
    pulse(258);
    rd(8'h58, 1, 8'h01);
    rd(8'h6c, 1, 8'h02);
    pulse(5);
    rd(8'h59, 1, 8'h05);
    rd(8'h6c, 2, 8'h00);
    pulse(2);
    rd(8'h58, 2, 8'h00);
    for (int f = 1; f < 4; f++) begin
      fmt = 2'(f);
      pulse(4);
      rd(8'h59, 1, 8'h00);
    end
    viol = 1'b1;
    repeat (3) @(negedge i_clk_sys);
    viol = 1'b0;
    rd(8'h51, 1, 8'h03);
  endtask
  // Events every cycle for over two intervals, so the last latched interval is full.
  task automatic t_sec;
    for (int f = 0; f < 4; f++) begin
      fmt = 2'(f);
      {viol, fpe, bit_stb} = 3'h7;
      repeat (2300) @(negedge i_clk_sys);
      rd(8'h6d, 1, 8'h03);
      rd(8'h6f, 1, 8'h4c);
      rd(8'h6e, 1, 8'h04);
      rd(8'h71, 1, 8'h4c);
      rd(8'h70, 1, 8'h04);
    end
    {viol, fpe} = 2'h0;
    repeat (2300) @(negedge i_clk_sys);
    rd(8'h6d, 1, 8'h00);
    rd(8'h71, 1, 8'h00);
  endtask
  // One error per 1100-bit interval is below 1 in 1000; two are above it.
  // The pulse period equals the interval, so each full interval sees n errors.
  task automatic t_rate;
    for (int n = 1; n < 3; n++) begin
      for (int i = 0; i < 4; i++) begin
        viol = 1'b1;
        repeat (n) @(negedge i_clk_sys);
        viol = 1'b0;
        repeat (1098 - n) @(negedge i_clk_sys);
        u_host.read(8'h6d, 1, d);
        if (i > 0) check(8'h6d, d, (n == 2) ? 8'h03 : 8'h02);
      end
    end
  endtask
  task automatic summarize;
    $display("Comparisons %0d, mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (6) @(negedge i_clk_sys);
    i_rst = 1'b0;
    t_ppb();
    t_sec();
    t_rate();
    summarize();
  end
  // The scenarios take about 21000 cycles; the limit leaves ample margin.
  initial begin
    #400000;
    fails++;
    summarize();
  end
endmodule
`default_nettype wire
